// [acm_ctrl.sv]
// module: clock, sample time, input mux, pin mode and scan control of the converter
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
module acm_ctrl (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [acm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [acm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [acm_pkg::DATA_W-1:0] reg_rdata,
	input wire logic rc_clk_pin,
	output acm_pkg::acm_analog_s analog_ctl,
	output logic tad_clk_out,
	output logic conv_start,
	output logic div_reserved
);
	logic [15:0] clk_sample_reg;
	logic [15:0] mux_sel_reg;
	logic [15:0] pin_cfg_reg;
	logic [15:0] scan_mask_reg;
	logic [15:0] seq_ctrl_reg;
	logic [15:0] rdata_reg;
	logic rc_sync1_reg;
	logic rc_sync2_reg;
	logic rc_prev_reg;
	logic use_b_reg;
	logic [3:0] scan_ch_reg;
	logic [4:0] samp_cnt_reg;
	logic [4:0] conv_cnt_reg;
	logic conv_start_reg;
	acm_pkg::acm_state_e state_reg;

	// register decode
	wire wr_clk = reg_wr & (reg_addr == acm_pkg::OFF_CLK_SAMPLE);
	wire wr_mux = reg_wr & (reg_addr == acm_pkg::OFF_MUX_SEL);
	wire wr_pin = reg_wr & (reg_addr == acm_pkg::OFF_PIN_CFG);
	wire wr_scan = reg_wr & (reg_addr == acm_pkg::OFF_SCAN_MASK);
	wire wr_seq = reg_wr & (reg_addr == acm_pkg::OFF_SEQ_CTRL);

	// fields
	wire clk_src_rc = clk_sample_reg[acm_pkg::CLK_SRC_BIT];
	wire [4:0] samp_periods = clk_sample_reg[acm_pkg::SAMP_LSB +: 5];
	wire [7:0] clk_div = clk_sample_reg[7:0];
	wire alt_en = seq_ctrl_reg[acm_pkg::SEQ_ALT_BIT];
	wire scan_en = seq_ctrl_reg[acm_pkg::SEQ_SCAN_BIT];
	wire [2:0] trig_sel = seq_ctrl_reg[acm_pkg::SEQ_TRIG_LSB +: 3];
	wire start_req = wr_seq & reg_wdata[acm_pkg::SEQ_START_BIT];
	wire [15:0] scan_set = {scan_mask_reg[acm_pkg::BG_BIT], 2'b00, scan_mask_reg[12:0]};

	// divider tick from the system clock path
	logic sys_tick;
	logic sys_tad;
	acm_tad_div #(.DIV_W(8)) u_div (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ce(ce),
		.divider(clk_div),
		.tick(sys_tick),
		.tad_clk(sys_tad)
	);

	// rc oscillator pin arrives asynchronously; the first stage feeds only the second
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rc_sync1_reg <= 1'b0;
			rc_sync2_reg <= 1'b0;
			rc_prev_reg <= 1'b0;
		end else if (ce) begin
			rc_sync1_reg <= rc_clk_pin;
			rc_sync2_reg <= rc_sync1_reg;
			rc_prev_reg <= rc_sync2_reg;
		end
	end
	wire rc_tick = ce & rc_sync2_reg & ~rc_prev_reg;
	wire tad_tick = clk_src_rc ? rc_tick : sys_tick;
	assign tad_clk_out = clk_src_rc ? rc_sync2_reg : sys_tad;
	assign div_reserved = (clk_div > acm_pkg::DIV_MAX_VALID);

	// next channel in ascending order above current, else wrap to lowest selected
	function automatic logic [3:0] next_scan(input logic [15:0] set, input logic [3:0] cur);
		logic [3:0] lowest;
		logic [3:0] above;
		logic found_low;
		logic found_above;
		lowest = '0;
		above = '0;
		found_low = 1'b0;
		found_above = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (set[i] && !found_low) begin
				lowest = 4'(i);
				found_low = 1'b1;
			end
			if (set[i] && (4'(i) > cur) && !found_above) begin
				above = 4'(i);
				found_above = 1'b1;
			end
		end
		return found_above ? above : lowest;
	endfunction

	// software registers; implemented bits only, all clear at reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			clk_sample_reg <= acm_pkg::RESET_VALUE;
			mux_sel_reg <= acm_pkg::RESET_VALUE;
			pin_cfg_reg <= acm_pkg::RESET_VALUE;
			scan_mask_reg <= acm_pkg::RESET_VALUE;
			seq_ctrl_reg <= acm_pkg::RESET_VALUE;
		end else if (ce) begin
			if (wr_clk) clk_sample_reg <= reg_wdata & acm_pkg::MASK_CLK_SAMPLE;
			if (wr_mux) mux_sel_reg <= reg_wdata & acm_pkg::MASK_MUX_SEL;
			if (wr_pin) pin_cfg_reg <= reg_wdata & acm_pkg::MASK_PIN_CFG;
			if (wr_scan) scan_mask_reg <= reg_wdata & acm_pkg::MASK_SCAN_MASK;
			if (wr_seq) seq_ctrl_reg <= reg_wdata & acm_pkg::MASK_SEQ_CTRL;
		end
	end

	// read mux: unmapped addresses read zero
	wire [15:0] status_word = {12'h000, scan_ch_reg[3:0] & 4'hF} | {11'h000, use_b_reg, 4'h0}
		| {state_reg == acm_pkg::ST_CONVERT, state_reg == acm_pkg::ST_SAMPLE, 14'h0000};
	wire [15:0] rd_mux =
		(reg_addr == acm_pkg::OFF_CLK_SAMPLE) ? clk_sample_reg :
		(reg_addr == acm_pkg::OFF_MUX_SEL) ? mux_sel_reg :
		(reg_addr == acm_pkg::OFF_PIN_CFG) ? pin_cfg_reg :
		(reg_addr == acm_pkg::OFF_SCAN_MASK) ? scan_mask_reg :
		(reg_addr == acm_pkg::OFF_SEQ_CTRL) ? seq_ctrl_reg :
		(reg_addr == acm_pkg::OFF_STATUS) ? status_word : 16'h0000;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata_reg <= 16'h0000;
		end else if (ce) begin
			rdata_reg <= reg_rd ? rd_mux : 16'h0000;
		end
	end
	assign reg_rdata = rdata_reg;

	// sample/convert sequencer
	wire samp_done = (samp_cnt_reg == 5'h00);
	wire conv_done = (conv_cnt_reg == 5'h00);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= acm_pkg::ST_IDLE;
			samp_cnt_reg <= 5'h00;
			conv_cnt_reg <= 5'h00;
			conv_start_reg <= 1'b0;
			use_b_reg <= 1'b0;
			scan_ch_reg <= 4'h0;
		end else if (ce) begin
			conv_start_reg <= 1'b0;
			case (state_reg)
				acm_pkg::ST_IDLE: begin
					if (start_req) begin
						state_reg <= acm_pkg::ST_SAMPLE;
						samp_cnt_reg <= samp_periods;
						use_b_reg <= 1'b0;
						scan_ch_reg <= next_scan(scan_set, 4'hF);
					end
				end
				acm_pkg::ST_SAMPLE: begin
					if (trig_sel == acm_pkg::TRIG_AUTO) begin
						if (samp_done) begin
							state_reg <= acm_pkg::ST_CONVERT;
							conv_cnt_reg <= acm_pkg::CONV_TAD_CNT;
							conv_start_reg <= 1'b1;
						end else if (tad_tick) begin
							samp_cnt_reg <= samp_cnt_reg - 5'h01;
						end
					end else if (start_req) begin
						state_reg <= acm_pkg::ST_CONVERT;
						conv_cnt_reg <= acm_pkg::CONV_TAD_CNT;
						conv_start_reg <= 1'b1;
					end
				end
				acm_pkg::ST_CONVERT: begin
					if (conv_done) begin
						samp_cnt_reg <= samp_periods;
						use_b_reg <= alt_en & ~use_b_reg;
						if (scan_en && !(alt_en && !use_b_reg)) begin
							scan_ch_reg <= next_scan(scan_set, scan_ch_reg);
						end
						// auto-convert keeps sampling; other triggers wait for a new start
						state_reg <= (trig_sel == acm_pkg::TRIG_AUTO) ? acm_pkg::ST_SAMPLE : acm_pkg::ST_IDLE;
					end else if (tad_tick) begin
						conv_cnt_reg <= conv_cnt_reg - 5'h01;
					end
				end
				default: state_reg <= acm_pkg::ST_IDLE;
			endcase
		end
	end
	assign conv_start = conv_start_reg;

	// analog front-end selection
	wire [3:0] pos_a = scan_en ? scan_ch_reg : mux_sel_reg[acm_pkg::POS_A_LSB +: 4];
	wire [3:0] pos_b = mux_sel_reg[acm_pkg::POS_B_LSB +: 4];
	wire neg_a = mux_sel_reg[acm_pkg::NEG_A_BIT];
	wire neg_b = mux_sel_reg[acm_pkg::NEG_B_BIT];
	assign analog_ctl.pos_sel = use_b_reg ? pos_b : pos_a;
	assign analog_ctl.neg_sel_an1 = use_b_reg ? neg_b : neg_a;
	assign analog_ctl.bandgap_en = ~pin_cfg_reg[acm_pkg::BG_BIT];
	assign analog_ctl.pin_analog = ~pin_cfg_reg[12:0];
	assign analog_ctl.sampling = (state_reg == acm_pkg::ST_SAMPLE);
	assign analog_ctl.converting = (state_reg == acm_pkg::ST_CONVERT);
endmodule

// [acm_ctrl_properties.sv]
// checker: port properties of the converter control block
module acm_ctrl_checker (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [acm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [acm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [acm_pkg::DATA_W-1:0] reg_rdata,
	input wire logic rc_clk_pin,
	input wire acm_pkg::acm_analog_s analog_ctl,
	input wire logic tad_clk_out,
	input wire logic conv_start,
	input wire logic div_reserved
);
	logic mode_reg;
	wire logic wr_pin = reg_wr && reg_addr == acm_pkg::OFF_PIN_CFG;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// set while the last sequence control write enables alternate or scan mode, cleared by one that enables neither
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mode_reg <= 1'b0;
		end else if (reg_wr && reg_addr == acm_pkg::OFF_SEQ_CTRL) begin
			mode_reg <= |reg_wdata[1:0];
		end
	end
	chk_rdata_quiet: assert property (ce && !reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
	chk_read_back: assert property (ce && reg_wr && reg_addr inside {4'h0, 4'h2, 4'h3}
		##1 ce && reg_rd && $stable(reg_addr) |=> reg_rdata == ($past(reg_wdata, 2) & 16'h9FFF))
		else $error("read back mismatch");
	chk_unmapped_zero: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_div_reserved: assert property (reg_wr && reg_addr == 4'h0
		|=> div_reserved == ($past(reg_wdata[7:0]) > 8'h3F)) else $error("reserved divider flag wrong");
	chk_bandgap_en: assert property (wr_pin |=> analog_ctl.bandgap_en != $past(reg_wdata[15]))
		else $error("band gap enable wrong");
	chk_pin_mode: assert property (wr_pin |=> analog_ctl.pin_analog == ~$past(reg_wdata[12:0]))
		else $error("pin mode wrong");
	chk_mux_setup_a: assert property (reg_wr && reg_addr == 4'h1 && !mode_reg && !analog_ctl.sampling
		&& !analog_ctl.converting |=> analog_ctl.neg_sel_an1 == $past(reg_wdata[7])
		&& analog_ctl.pos_sel == $past(reg_wdata[3:0])) else $error("setup A selection wrong");
	chk_start_pulse: assert property (conv_start && ce |=> !conv_start)
		else $error("start pulse too long");
endmodule
bind acm_ctrl acm_ctrl_checker chk (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_clk_pin(rc_clk_pin),
	.analog_ctl(analog_ctl), .tad_clk_out(tad_clk_out), .conv_start(conv_start), .div_reserved(div_reserved));

// [acm_pkg.sv]
// package: register map, field layout and constants of the converter control block
package acm_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// register indices on the plain register port
	localparam logic [3:0] OFF_CLK_SAMPLE = 4'h0;
	localparam logic [3:0] OFF_MUX_SEL = 4'h1;
	localparam logic [3:0] OFF_PIN_CFG = 4'h2;
	localparam logic [3:0] OFF_SCAN_MASK = 4'h3;
	localparam logic [3:0] OFF_SEQ_CTRL = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h5;
	// implemented-bit masks, unimplemented bits read zero
	localparam logic [15:0] MASK_CLK_SAMPLE = 16'h9FFF;
	localparam logic [15:0] MASK_MUX_SEL = 16'h8F8F;
	localparam logic [15:0] MASK_PIN_CFG = 16'h9FFF;
	localparam logic [15:0] MASK_SCAN_MASK = 16'h9FFF;
	localparam logic [15:0] MASK_SEQ_CTRL = 16'h00F3;
	// field positions
	localparam int CLK_SRC_BIT = 15;
	localparam int SAMP_LSB = 8;
	localparam int NEG_B_BIT = 15;
	localparam int POS_B_LSB = 8;
	localparam int NEG_A_BIT = 7;
	localparam int POS_A_LSB = 0;
	localparam int BG_BIT = 15;
	localparam int SEQ_ALT_BIT = 0;
	localparam int SEQ_SCAN_BIT = 1;
	localparam int SEQ_TRIG_LSB = 4;
	localparam int SEQ_START_BIT = 7;
	// constants
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	localparam logic [7:0] DIV_MAX_VALID = 8'h3F;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	localparam logic [3:0] CH_BANDGAP = 4'hF;
	localparam int NUM_AN = 13;
	localparam int CONV_TAD = 12;
	localparam logic [4:0] CONV_TAD_CNT = 5'(CONV_TAD);

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acm_state_e;

	// settings that steer the analog front end
	typedef struct packed {
		logic [3:0] pos_sel;
		logic neg_sel_an1;
		logic bandgap_en;
		logic [12:0] pin_analog;
		logic sampling;
		logic converting;
	} acm_analog_s;
endpackage

// [acm_rc_osc_model.sv]
// model: free-running internal RC oscillator of the analog side
module acm_rc_osc_model #(
	parameter int HALF_NS = 170
) (
	output logic rc_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	// runs free, unrelated in phase to the system clock
	initial begin
		rc_clk = 1'b0;
		forever #(HALF_NS) rc_clk = ~rc_clk;
	end
endmodule

// [acm_tad_div.sv]
// module: conversion clock period divider producing one tick per period
module acm_tad_div #(
	parameter int DIV_W = 8
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [DIV_W-1:0] divider,
	output logic tick,
	output logic tad_clk
);
	logic [DIV_W-1:0] cnt_reg;
	logic tog_reg;
	wire at_end = (cnt_reg == '0);

	// reload from divider so a period lasts divider+1 cycles
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			tog_reg <= 1'b0;
		end else if (ce) begin
			cnt_reg <= at_end ? divider : cnt_reg - 1'b1;
			if (at_end) begin
				tog_reg <= ~tog_reg;
			end
		end
	end
	assign tick = ce & at_end;
	assign tad_clk = tog_reg;
endmodule

// [tb.sv]
// testbench: register, mux, pin mode, clock and scan checks
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, sys_rst, ce, reg_wr, reg_rd, tad_clk_out, conv_start, div_reserved, rc_clk;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	acm_pkg::acm_analog_s analog_ctl;
	int errors, compares, cycles, n;
	wire logic [2:0] st = {analog_ctl.sampling, conv_start, analog_ctl.converting};
	acm_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_clk_pin(rc_clk), .analog_ctl(analog_ctl),
		.tad_clk_out(tad_clk_out), .conv_start(conv_start), .div_reserved(div_reserved));
	acm_rc_osc_model osc (.rc_clk(rc_clk));
	// system clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			conclude();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one bus cycle; a read compares the data of the next cycle
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		if (!w) #1 check(reg_rdata, d);
	endtask
	task automatic idle();
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge mclk);
		#1;
	endtask
	// counts conversion clock rises over 200 cycles
	task automatic rises(input int lo, input int hi);
		logic last;
		n = 0;
		last = tad_clk_out;
		repeat (200) begin
			@(posedge mclk);
			n += int'(tad_clk_out && !last);
			last = tad_clk_out;
		end
		check({15'h0, n >= lo && n <= hi}, 16'h0001);
	endtask
	task automatic wait_st(input int b, input logic v);
		n = 0;
		while (st[b] !== v && n < 400) begin
			@(posedge mclk);
			#1 n++;
		end
		check({15'h0, st[b]}, {15'h0, v});
	endtask
	task automatic conclude();
		if (errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		{sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 22'h0};
		ce = 1'b1;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++) acc(1'b0, 4'(i), 16'h0000);
		check({analog_ctl.bandgap_en, 2'h0, analog_ctl.pin_analog}, 16'h9FFF);
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, 4'(i), 16'hFFFF);
			acc(1'b0, 4'(i), i == 1 ? 16'h8F8F : 16'h9FFF);
		end
		acc(1'b0, 4'hF, 16'h0000);
		check({15'h0, div_reserved}, 16'h0001);
		acc(1'b1, acm_pkg::OFF_CLK_SAMPLE, 16'h003F);
		idle();
		check({15'h0, div_reserved}, 16'h0000);
		// every legal positive code written to both setups and read back whole, front-end selection checked on setup A only
		for (int c = 0; c < 16; c++) begin
			if (c == 13 || c == 14) continue;
			acc(1'b1, acm_pkg::OFF_MUX_SEL, {c[1], 3'h0, 4'(c), c[0], 3'h0, 4'(c)});
			acc(1'b0, acm_pkg::OFF_MUX_SEL, {c[1], 3'h0, 4'(c), c[0], 3'h0, 4'(c)});
			check({11'h0, analog_ctl.neg_sel_an1, analog_ctl.pos_sel}, {11'h0, c[0], 4'(c)});
		end
		acc(1'b1, acm_pkg::OFF_PIN_CFG, 16'h81C0);
		idle();
		check({analog_ctl.bandgap_en, 2'h0, analog_ctl.pin_analog}, 16'h1E3F);
		acc(1'b1, acm_pkg::OFF_CLK_SAMPLE, 16'h8000);
		idle();
		rises(10, 13);
		acc(1'b1, acm_pkg::OFF_CLK_SAMPLE, 16'h0003);
		idle();
		rises(24, 50);
		// auto-convert scan over channels 1 and 3, wrapping
		acc(1'b1, acm_pkg::OFF_CLK_SAMPLE, 16'h0201);
		acc(1'b1, acm_pkg::OFF_SCAN_MASK, 16'h000A);
		for (int k = 0; k < 3; k++) begin
			acc(1'b1, acm_pkg::OFF_SEQ_CTRL, 16'h00F2);
			idle();
			wait_st(2, 1'b1);
			check({12'h0, analog_ctl.pos_sel}, k == 1 ? 16'h0003 : 16'h0001);
			wait_st(1, 1'b1);
			wait_st(0, 1'b1);
			wait_st(0, 1'b0);
		end
		// clock enable low freezes the registers
		ce <= 1'b0;
		acc(1'b1, acm_pkg::OFF_SCAN_MASK, 16'h0055);
		ce <= 1'b1;
		acc(1'b0, acm_pkg::OFF_SCAN_MASK, 16'h000A);
		idle();
		// reset in mid-run, then alternate setups A then B
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		acc(1'b0, acm_pkg::OFF_SCAN_MASK, 16'h0000);
		acc(1'b1, acm_pkg::OFF_CLK_SAMPLE, 16'h0201);
		acc(1'b1, acm_pkg::OFF_MUX_SEL, 16'h8502);
		acc(1'b1, acm_pkg::OFF_SEQ_CTRL, 16'h00F1);
		idle();
		wait_st(2, 1'b1);
		check({11'h0, analog_ctl.neg_sel_an1, analog_ctl.pos_sel}, 16'h0002);
		wait_st(0, 1'b1);
		wait_st(0, 1'b0);
		check({11'h0, analog_ctl.neg_sel_an1, analog_ctl.pos_sel}, 16'h0015);
		conclude();
	end
endmodule
